//--- hw/gms_pkg.sv
// Package for the gas sensor measurement sequencer: register map, fields, timing
package gms_pkg;
    // Register indices on the plain register port (byte wide data)
    localparam logic [7:0] GMS_PRESSURE_REFERENCE_HIGH = 8'h00;
    localparam logic [7:0] GMS_PRESSURE_REFERENCE_LOW = 8'h01;
    localparam logic [7:0] GMS_THRESHOLD_HIGH_BYTE = 8'h02;
    localparam logic [7:0] GMS_THRESHOLD_LOW_BYTE = 8'h03;
    localparam logic [7:0] GMS_MEAS_CFG = 8'h04;
    localparam logic [7:0] GMS_PERIOD_HIGH = 8'h05;
    localparam logic [7:0] GMS_PERIOD_LOW = 8'h06;
    localparam logic [7:0] GMS_INT_CFG = 8'h07;
    localparam logic [7:0] GMS_MEASUREMENT_STATUS_REG = 8'h08;
    localparam logic [7:0] GMS_SENSOR_STATUS_REG = 8'h09;
    localparam logic [7:0] GMS_RESULT_HIGH = 8'h0a;
    localparam logic [7:0] GMS_RESULT_LOW = 8'h0b;
    localparam logic [7:0] GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_HIGH = 8'h0c;
    localparam logic [7:0] GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_LOW = 8'h0d;
    localparam logic [7:0] GMS_RAW_SAMPLE_HIGH = 8'h0e;
    localparam logic [7:0] GMS_RAW_SAMPLE_LOW = 8'h0f;
    // Field positions in the measurement and interrupt configuration registers
    localparam int GMS_MODE_LSB = 0;
    localparam int GMS_ABC_EN_BIT = 2;
    localparam int GMS_FORCED_EN_BIT = 3;
    localparam int GMS_ALARM_EN_BIT = 0;
    // Field positions in the measurement status register
    localparam int GMS_ST_RDY_BIT = 4;
    localparam int GMS_ST_ALARM_BIT = 3;
    localparam int GMS_ST_BUSY_BIT = 0;
    // Reset values
    localparam logic [11:0] GMS_PERIOD_RESET = 12'h03c;
    localparam logic [15:0] GMS_PRESSURE_RESET = 16'h03f5;
    localparam logic [15:0] GMS_THRESHOLD_RESET = 16'h0000;
    localparam logic [15:0] GMS_SETPOINT_RESET = 16'h0190;
    // Timing
    localparam int GMS_CLK_HZ = 100_000_000;
    localparam int GMS_BAUD_HZ = 9600;
    localparam int GMS_BAUD_CYCLES = GMS_CLK_HZ / GMS_BAUD_HZ;
    localparam int GMS_PERIOD_MIN_S = 5;
    localparam int GMS_PERIOD_MAX_S = 4095;
    localparam int GMS_SEQ_CYCLES = 16;
    localparam int GMS_FORCED_COUNT = 3;
    localparam int GMS_WEEK_S = 604800;
    localparam int GMS_PRESSURE_NOMINAL = 1013;
    // Operating modes
    typedef enum logic [1:0] {
        GMS_MODE_IDLE = 2'h0,
        GMS_MODE_SINGLE = 2'h1,
        GMS_MODE_CONTINUOUS = 2'h2
    } gms_mode_t;
    // Register request bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gms_req_t;
endpackage

//--- hw/gms_sequencer.sv
// Gas sensor measurement sequencer: registers, UART responder, modes and post-processing
`timescale 1ns/100ps
module gms_sequencer #(
    parameter int CLK_HZ = gms_pkg::GMS_CLK_HZ,
    parameter int WEEK_S = gms_pkg::GMS_WEEK_S,
    parameter int BAUD_CYCLES = gms_pkg::GMS_BAUD_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire gms_pkg::gms_req_t reg_req,
    output logic [7:0] reg_rdata,
    // UART link
    input wire logic uart_rx,
    output logic uart_tx,
    // Pins and transducer
    input wire logic measurement_disable_pin,
    input wire logic [15:0] sample_raw,
    output logic alarm_int_n,
    output logic active_q
);
    import gms_pkg::*;
    //////////////////////////////////////////////////////////////////
    // Declarations
    typedef enum logic [1:0] {GMS_S_SLEEP, GMS_S_MEASURE, GMS_S_POST} gms_state_t;
    gms_state_t state_q; // Sequencer state
    logic [1:0] mode_q; // Operating mode field
    logic abc_en_q, forced_en_q, alarm_en_q; // Configuration bits
    logic [11:0] period_q; // Continuous period in seconds
    logic [15:0] press_q, thr_q, setpoint_q; // Host references
    logic [15:0] result_q; // Stored concentration
    logic signed [16:0] offset_q; // Applied baseline offset
    logic signed [18:0] forced_acc_q; // Forced compensation sum
    logic [1:0] forced_cnt_q; // Forced sequences seen
    logic alarm_q, ready_q, pin_q, init_q; // Status and edge memory
    logic [31:0] sec_div_q; // Second divider
    logic sec_tick; // One-cycle second pulse
    logic [11:0] sec_cnt_q; // Seconds into the period
    logic [31:0] week_q; // Seconds of operation
    logic [7:0] seq_cnt_q; // Sequence duration counter
    logic rx_byte_stb; // UART byte received pulse
    logic [7:0] rx_byte; // Received byte
    logic [15:0] comp_val; // Compensated concentration
    logic [31:0] prod; // Pressure product
    logic start_req; // Sequence start request

    //////////////////////////////////////////////////////////////////
    // Helpers
    // Byte select for 16-bit registers
    function automatic logic [7:0] gms_byte(input logic [15:0] v, input logic hi);
        gms_byte = hi ? v[15:8] : v[7:0];
    endfunction

    //////////////////////////////////////////////////////////////////
    // One-second enable pulse from a divider
    always_ff @(posedge mclk) begin
        if (!rst_n || sec_div_q == 32'(CLK_HZ - 1)) begin
            sec_div_q <= 32'h0;
        end else begin
            sec_div_q <= sec_div_q + 32'h1;
        end
    end
    assign sec_tick = (sec_div_q == 32'(CLK_HZ - 1));

    //////////////////////////////////////////////////////////////////
    // UART receiver, 8N1; the device never initiates on the link
    logic [15:0] rx_cnt_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic rx_busy_q, rx_stb_q;
    always_ff @(posedge mclk) begin
        rx_stb_q <= 1'b0;
        if (!rst_n) begin
            rx_busy_q <= 1'b0;
            rx_cnt_q <= 16'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
        end else if (!rx_busy_q) begin
            if (!uart_rx) begin // Start bit, sample at its middle
                rx_busy_q <= 1'b1;
                rx_cnt_q <= 16'(BAUD_CYCLES / 2);
                rx_bit_q <= 4'h0;
            end
        end else if (rx_cnt_q != 16'h0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
        end else begin
            rx_cnt_q <= 16'(BAUD_CYCLES - 1);
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && uart_rx) begin
                rx_busy_q <= 1'b0; // False start, glitch rejected
            end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
                rx_sh_q <= {uart_rx, rx_sh_q[7:1]}; // LSB first
            end else if (rx_bit_q == 4'h9) begin
                rx_busy_q <= 1'b0;
                rx_stb_q <= uart_rx; // Framing error drops the byte
            end
        end
    end
    assign rx_byte_stb = rx_stb_q;
    assign rx_byte = rx_sh_q;

    //////////////////////////////////////////////////////////////////
    // UART transmitter echoes each byte as acknowledgement; responder only
    logic [9:0] tx_sh_q;
    logic [3:0] tx_bit_q;
    logic [15:0] tx_cnt_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_sh_q <= 10'h3ff;
            tx_bit_q <= 4'h0;
            tx_cnt_q <= 16'h0;
            uart_tx <= 1'b1;
        end else if (tx_bit_q == 4'h0) begin
            uart_tx <= 1'b1;
            if (rx_byte_stb) begin // Only answers a received byte
                tx_sh_q <= {1'b1, rx_byte, 1'b0}; // Start, data, stop
                tx_bit_q <= 4'ha;
                tx_cnt_q <= 16'h0;
            end
        end else if (tx_cnt_q != 16'h0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
        end else begin
            uart_tx <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_cnt_q <= 16'(BAUD_CYCLES - 1);
            tx_bit_q <= tx_bit_q - 4'h1;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Host configuration writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            press_q <= GMS_PRESSURE_RESET;
            thr_q <= GMS_THRESHOLD_RESET;
            setpoint_q <= GMS_SETPOINT_RESET;
            period_q <= GMS_PERIOD_RESET;
            abc_en_q <= 1'b0;
            forced_en_q <= 1'b0;
            alarm_en_q <= 1'b0;
        end else begin
            if (reg_req.wr) begin
                if (reg_req.addr == GMS_PRESSURE_REFERENCE_HIGH) begin
                    press_q[15:8] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_PRESSURE_REFERENCE_LOW) begin
                    press_q[7:0] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_THRESHOLD_HIGH_BYTE) begin
                    thr_q[15:8] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_THRESHOLD_LOW_BYTE) begin
                    thr_q[7:0] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_PERIOD_HIGH) begin
                    period_q[11:8] <= reg_req.wdata[3:0];
                end else if (reg_req.addr == GMS_PERIOD_LOW) begin
                    period_q[7:0] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_INT_CFG) begin
                    alarm_en_q <= reg_req.wdata[GMS_ALARM_EN_BIT];
                end else if (reg_req.addr == GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_HIGH) begin
                    setpoint_q[15:8] <= reg_req.wdata; // Host keeps it in range
                end else if (reg_req.addr == GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_LOW) begin
                    setpoint_q[7:0] <= reg_req.wdata;
                end else if (reg_req.addr == GMS_MEAS_CFG) begin
                    abc_en_q <= reg_req.wdata[GMS_ABC_EN_BIT];
                    forced_en_q <= reg_req.wdata[GMS_FORCED_EN_BIT];
                end
            end
            // Forced compensation disables itself after the third sequence
            if (state_q == GMS_S_POST && forced_en_q && forced_cnt_q == 2'(GMS_FORCED_COUNT - 1)) begin
                forced_en_q <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // Operating mode; a write during a sequence is held until it ends
    logic [1:0] mode_pend_q;
    logic mode_pend_v_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_q <= GMS_MODE_IDLE; // Power-up in idle
            mode_pend_q <= GMS_MODE_IDLE;
            mode_pend_v_q <= 1'b0;
        end else if (reg_req.wr && reg_req.addr == GMS_MEAS_CFG && state_q == GMS_S_MEASURE) begin
            mode_pend_q <= reg_req.wdata[GMS_MODE_LSB +: 2]; // Deferred
            mode_pend_v_q <= 1'b1;
        end else if (reg_req.wr && reg_req.addr == GMS_MEAS_CFG) begin
            mode_q <= reg_req.wdata[GMS_MODE_LSB +: 2];
        end else if (state_q == GMS_S_POST) begin
            if (mode_pend_v_q) begin
                mode_q <= mode_pend_q; // Applied at sequence end
                mode_pend_v_q <= 1'b0;
            end else if (mode_q == GMS_MODE_SINGLE) begin
                mode_q <= GMS_MODE_IDLE; // One shot done
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // Period timer and weekly operation counter
    always_ff @(posedge mclk) begin
        if (!rst_n || mode_q != GMS_MODE_CONTINUOUS || start_req) begin
            sec_cnt_q <= 12'h0;
        end else if (sec_tick) begin
            sec_cnt_q <= sec_cnt_q + 12'h1;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n || (state_q == GMS_S_POST && week_q >= 32'(WEEK_S))) begin
            week_q <= 32'h0;
        end else if (sec_tick) begin
            week_q <= week_q + 32'h1;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Start conditions; period clamped to its legal range
    logic [11:0] period_eff;
    always_comb begin
        period_eff = period_q;
        if (period_q < 12'(GMS_PERIOD_MIN_S)) begin
            period_eff = 12'(GMS_PERIOD_MIN_S);
        end
        start_req = 1'b0;
        if (state_q == GMS_S_SLEEP) begin
            if (mode_q == GMS_MODE_CONTINUOUS && sec_cnt_q >= period_eff) begin
                start_req = 1'b1; // Internal request
            end else if (mode_q == GMS_MODE_SINGLE) begin
                start_req = 1'b1;
            end else if (mode_q != GMS_MODE_IDLE && pin_q && !measurement_disable_pin) begin
                start_req = 1'b1; // Falling edge on pin idle never measures
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= GMS_S_SLEEP;
            seq_cnt_q <= 8'h0;
        end else begin
            case (state_q)
                GMS_S_SLEEP: begin
                    if (start_req) begin
                        state_q <= GMS_S_MEASURE;
                        seq_cnt_q <= 8'(GMS_SEQ_CYCLES - 1);
                    end
                end
                GMS_S_MEASURE: begin
                    if (seq_cnt_q == 8'h0) begin
                        state_q <= GMS_S_POST;
                    end else begin
                        seq_cnt_q <= seq_cnt_q - 8'h1;
                    end
                end
                default: begin
                    state_q <= GMS_S_SLEEP; // Nothing pending, sleep
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////
    // Active indicator: any task wakes the core briefly
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            pin_q <= 1'b1;
        end else begin
            pin_q <= measurement_disable_pin;
            // Receive or pin edge wakes briefly, sequence keeps awake
            active_q <= (state_q != GMS_S_SLEEP) || start_req || rx_busy_q || rx_byte_stb
                || (pin_q && !measurement_disable_pin) || tx_bit_q != 4'h0;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Post-processing: pressure scaling then offset
    logic signed [17:0] with_off;
    always_comb begin
        prod = 32'(sample_raw) * 32'(GMS_PRESSURE_NOMINAL);
        if (press_q != 16'h0) begin
            prod = prod / 32'(press_q);
        end
        with_off = $signed({2'b00, prod[15:0]}) - 18'(offset_q);
        if (with_off < 0) begin
            comp_val = 16'h0;
        end else if (with_off > 18'sh0ffff) begin
            comp_val = 16'hffff;
        end else begin
            comp_val = with_off[15:0];
        end
    end

    //////////////////////////////////////////////////////////////////
    // Result store, offsets, alarm and ready
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            result_q <= 16'h0;
            offset_q <= 17'sh0;
            forced_acc_q <= 19'sh0;
            forced_cnt_q <= 2'h0;
            alarm_q <= 1'b0;
            ready_q <= 1'b0;
            init_q <= 1'b0;
            alarm_int_n <= 1'b1;
        end else begin
            init_q <= 1'b1;
            ready_q <= ready_q | init_q; // Set once start-up is done
            if (reg_req.rd && reg_req.addr == GMS_MEASUREMENT_STATUS_REG) begin
                alarm_q <= 1'b0; // Clear on read
            end
            if (state_q == GMS_S_POST) begin
                result_q <= comp_val;
                if (alarm_en_q && comp_val > thr_q) begin
                    alarm_q <= 1'b1; // Set beats clear
                end
                if (abc_en_q && week_q >= 32'(WEEK_S)) begin
                    // New baseline from drift against setpoint
                    offset_q <= offset_q + 17'($signed({1'b0, comp_val}) - $signed({1'b0, setpoint_q}));
                end
                if (forced_en_q) begin
                    if (forced_cnt_q == 2'(GMS_FORCED_COUNT - 1)) begin
                        // Average error of three runs is added to the offset
                        offset_q <= offset_q + 17'((forced_acc_q + 19'($signed({1'b0, comp_val}))
                            - 19'sd3 * 19'($signed({1'b0, setpoint_q}))) / 19'sd3);
                        forced_acc_q <= 19'sh0;
                        forced_cnt_q <= 2'h0;
                    end else begin
                        forced_acc_q <= forced_acc_q + 19'($signed({1'b0, comp_val}));
                        forced_cnt_q <= forced_cnt_q + 2'h1;
                    end
                end
            end
            alarm_int_n <= !(alarm_q && alarm_en_q);
        end
    end

    //////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n || !reg_req.rd) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.addr == GMS_PRESSURE_REFERENCE_HIGH) begin
            reg_rdata <= gms_byte(press_q, 1'b1);
        end else if (reg_req.addr == GMS_PRESSURE_REFERENCE_LOW) begin
            reg_rdata <= gms_byte(press_q, 1'b0);
        end else if (reg_req.addr == GMS_THRESHOLD_HIGH_BYTE) begin
            reg_rdata <= gms_byte(thr_q, 1'b1);
        end else if (reg_req.addr == GMS_THRESHOLD_LOW_BYTE) begin
            reg_rdata <= gms_byte(thr_q, 1'b0);
        end else if (reg_req.addr == GMS_MEAS_CFG) begin
            reg_rdata <= {4'h0, forced_en_q, abc_en_q, mode_q};
        end else if (reg_req.addr == GMS_PERIOD_HIGH) begin
            reg_rdata <= {4'h0, period_q[11:8]};
        end else if (reg_req.addr == GMS_PERIOD_LOW) begin
            reg_rdata <= period_q[7:0];
        end else if (reg_req.addr == GMS_INT_CFG) begin
            reg_rdata <= {7'h00, alarm_en_q};
        end else if (reg_req.addr == GMS_MEASUREMENT_STATUS_REG) begin
            reg_rdata <= {3'h0, ready_q, alarm_q, 2'h0, state_q != GMS_S_SLEEP};
        end else if (reg_req.addr == GMS_SENSOR_STATUS_REG) begin
            reg_rdata <= {ready_q, 7'h00};
        end else if (reg_req.addr == GMS_RESULT_HIGH) begin
            reg_rdata <= gms_byte(result_q, 1'b1);
        end else if (reg_req.addr == GMS_RESULT_LOW) begin
            reg_rdata <= gms_byte(result_q, 1'b0);
        end else if (reg_req.addr == GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_HIGH) begin
            reg_rdata <= gms_byte(setpoint_q, 1'b1);
        end else if (reg_req.addr == GMS_AUTOMATIC_BASELINE_CORRECTION_SETPOINT_LOW) begin
            reg_rdata <= gms_byte(setpoint_q, 1'b0);
        end else begin
            reg_rdata <= 8'h00; // Unmapped reads as zero
        end
    end
endmodule

//--- verif/gms_host_model.sv
// Host side of the UART link: sends frames and listens for the answer
`timescale 1ns/100ps
module gms_host_model #(
    parameter int BIT_CYC = 8
) (
    // Clock
    input wire logic mclk,
    // Link
    output logic uart_rx,
    input wire logic uart_tx
);
    logic [7:0] echo_q; // Last byte heard back
    initial uart_rx = 1'b1;
    // One frame: start, eight data bits lsb first, stop; line rests high
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            uart_rx <= f[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask
    // Wait bounded for a start bit, then sample each of the eight data bits in its middle
    task automatic hear(output logic ok);
        ok = 1'b0;
        for (int t = 0; t < 400 && !ok; t++) begin
            @(posedge mclk);
            ok = !uart_tx;
        end
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            echo_q[i] = uart_tx;
        end
    endtask
endmodule

//--- verif/gms_monitor.sv
// Port checker for the measurement sequencer
`timescale 1ns/100ps
module gms_monitor #(
    parameter int BAUD_CYCLES = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port and pins
    input wire gms_pkg::gms_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic uart_rx,
    input wire logic uart_tx,
    input wire logic alarm_int_n,
    input wire logic active_q
);
    import gms_pkg::*;
    localparam int STOP_MID = 9 * BAUD_CYCLES + BAUD_CYCLES / 2;
    logic [7:0] tx_cnt_q; // Cycle inside an outgoing frame, 0 when idle
    logic [7:0] quiet_q; // Cycles since the receive line was low, saturating
    logic clr_evt; // Status read or alarm enable write
    assign clr_evt = (reg_req.rd && reg_req.addr == GMS_MEASUREMENT_STATUS_REG)
        || (reg_req.wr && reg_req.addr == GMS_INT_CFG);
    // Frame position; a frame is ten bit times long
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_cnt_q <= 8'h00;
        end else if (tx_cnt_q == 8'h00) begin
            tx_cnt_q <= {7'h00, !uart_tx};
        end else begin
            tx_cnt_q <= (tx_cnt_q == 8'(10 * BAUD_CYCLES - 1)) ? 8'h00 : tx_cnt_q + 8'h01;
        end
    end
    // Saturates so a long silence never wraps into a false answer window
    always_ff @(posedge mclk) begin
        if (!rst_n || !uart_rx) begin
            quiet_q <= 8'h00;
        end else if (quiet_q != 8'hff) begin
            quiet_q <= quiet_q + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_rdata_quiet: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    a_tx_start_low: assert property (tx_cnt_q != 8'h00 && tx_cnt_q < 8'(BAUD_CYCLES) |-> !uart_tx)
        else $error("start bit too short");
    a_tx_stop_high: assert property (tx_cnt_q == 8'(STOP_MID) |-> uart_tx)
        else $error("stop bit missing");
    a_tx_answer_only: assert property (tx_cnt_q == 8'h01 |-> quiet_q < 8'(12 * BAUD_CYCLES))
        else $error("frame sent without a request");
    a_active_ends: assert property ($rose(active_q) |-> ##[1:400] !active_q)
        else $error("core never went inactive");
    a_alarm_read_clear: assert property (clr_evt && reg_req.rd && !active_q |-> ##[1:2] alarm_int_n)
        else $error("status read left alarm set");
    a_alarm_sticky: assert property ($rose(alarm_int_n) |-> $past(clr_evt) || $past(clr_evt, 2))
        else $error("alarm dropped by itself");
    a_ready_flag: assert property (reg_req.rd && reg_req.addr == GMS_SENSOR_STATUS_REG
        && $past(rst_n) && $past(rst_n, 2) |=> reg_rdata[7]) else $error("ready flag not set");
endmodule
bind gms_sequencer gms_monitor #(.BAUD_CYCLES(BAUD_CYCLES)) mon (.mclk(mclk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .alarm_int_n(alarm_int_n), .active_q(active_q));

//--- verif/gms_sequencer_bench.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
module gms_sequencer_bench;
    import gms_pkg::*;
    logic mclk; // 100 MHz clock
    logic rst_n; // Synchronous reset, active low
    gms_req_t reg_req; // Register request
    logic [7:0] reg_rdata; // Read answer
    logic uart_rx; // Host to device
    logic uart_tx; // Device to host
    logic [15:0] sample_raw; // Transducer value
    logic alarm_int_n; // Alarm pin
    logic active_q; // Core awake
    logic dis_pin = 1'b1; // Disable pin, idle high
    logic [15:0] lfsr_q = 16'h002d; // Stimulus source
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0; // Hang guard
    // Short seconds and baud times
    gms_sequencer #(.CLK_HZ(20), .WEEK_S(3), .BAUD_CYCLES(8)) uut (.mclk(mclk), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .uart_rx(uart_rx), .uart_tx(uart_tx),
        .measurement_disable_pin(dis_pin), .sample_raw(sample_raw), .alarm_int_n(alarm_int_n),
        .active_q(active_q));
    gms_host_model #(.BIT_CYC(8)) host (.mclk(mclk), .uart_rx(uart_rx), .uart_tx(uart_tx));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Pressure scaling against the nominal 1013
    function automatic logic [15:0] comp(input logic [15:0] raw, input logic [15:0] p);
        return 16'((32'(raw) * 32'd1013) / 32'(p));
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        reg_req <= '0;
    endtask
    // Answer lands one cycle after the strobe; sample once it settles
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        reg_req <= '0;
        #1 d = reg_rdata;
    endtask
    // Wait for one sequence to start and finish, bounded
    task automatic run_seq();
        int n;
        n = 0;
        while (active_q !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        while (active_q !== 1'b0 && n < 600) begin
            @(posedge mclk);
            n++;
        end
        check(n < 600, 1'b1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        logic [7:0] d;
        logic [7:0] h;
        logic [15:0] raw;
        logic [15:0] p;
        logic [15:0] th;
        logic [15:0] exp;
        logic ok;
        logic woke;
        int gap;
        reg_req = '0;
        sample_raw = 16'h0000;
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(GMS_SENSOR_STATUS_REG, d);
        check(d[7], 1'b1);
        rd(GMS_MEAS_CFG, d);
        check(d[1:0], GMS_MODE_IDLE);
        wr(GMS_INT_CFG, 8'h01);
        // Single shots: two pressures, alarm above, below and at the threshold
        for (int i = 0; i < 4; i++) begin
            lfsr_q = nxt(lfsr_q);
            raw = {4'h0, lfsr_q[11:0]};
            p = i[0] ? 16'h07ea : GMS_PRESSURE_RESET;
            exp = comp(raw, p);
            th = (i == 3) ? exp : (i[1] ? raw + 16'h0400 : raw >> 2);
            sample_raw <= raw;
            wr(GMS_PRESSURE_REFERENCE_HIGH, p[15:8]);
            wr(GMS_PRESSURE_REFERENCE_LOW, p[7:0]);
            wr(GMS_THRESHOLD_HIGH_BYTE, th[15:8]);
            wr(GMS_THRESHOLD_LOW_BYTE, th[7:0]);
            wr(GMS_MEAS_CFG, {6'h00, GMS_MODE_SINGLE});
            run_seq();
            rd(GMS_MEAS_CFG, d);
            check(d[1:0], GMS_MODE_IDLE);
            rd(GMS_RESULT_HIGH, h);
            rd(GMS_RESULT_LOW, d);
            check({h, d}, exp);
            check(alarm_int_n, !(exp > th));
            rd(GMS_MEASUREMENT_STATUS_REG, d);
            check(d[3], exp > th);
            rd(GMS_MEASUREMENT_STATUS_REG, d);
            check(d[3], 1'b0);
        end
        // Continuous at the shortest period, then idle requested mid sequence
        wr(GMS_PERIOD_HIGH, 8'h00);
        wr(GMS_PERIOD_LOW, 8'h05);
        wr(GMS_MEAS_CFG, {6'h00, GMS_MODE_CONTINUOUS});
        run_seq();
        gap = 0;
        while (active_q !== 1'b1 && gap < 300) begin
            @(posedge mclk);
            gap++;
        end
        check(gap inside {[70:100]}, 1'b1);
        wr(GMS_MEAS_CFG, {6'h00, GMS_MODE_IDLE});
        check(active_q, 1'b1);
        run_seq();
        gap = 0;
        dis_pin <= 1'b0;
        repeat (300) begin
            @(posedge mclk);
            gap += int'(active_q === 1'b1);
        end
        check(gap == 1, 1'b1);
        // Serial byte in, echo out, core wakes on reception
        lfsr_q = nxt(lfsr_q);
        woke = 1'b0;
        @(posedge mclk);
        fork
            host.send(lfsr_q[7:0]);
            host.hear(ok);
            repeat (160) begin
                @(posedge mclk);
                woke |= (active_q === 1'b1);
            end
        join
        check(ok, 1'b1);
        check(host.echo_q, lfsr_q[7:0]);
        check(woke, 1'b1);
        // Forced offset at the advised rate
        wr(GMS_PERIOD_LOW, 8'h0a);
        wr(GMS_MEAS_CFG, 8'h0a);
        repeat (4) run_seq();
        rd(GMS_RESULT_HIGH, h);
        rd(GMS_RESULT_LOW, d);
        check({h, d}, GMS_SETPOINT_RESET);
        conclude();
    end
endmodule
